// ---- src/fault_defs.svh ----
/*
 * Offsets, field positions, reset values and counts of the fault latch and mask bank.
 * Assumes the includer is a design file of the fault latch and mask block.
 */
// How it works
// [RULE_01] Supply fault latch at DC, resets zero.
// [RULE_02] Bit seven flags any logged change.
// [RULE_03] Bits six to zero hold supply faults.
// [RULE_04] Input fault latch at DD, top bits reserved.
// [RULE_05] Bits three to zero flag logic input changes.
// [RULE_06] Bit four flags watchdog output changes.
// [RULE_07] Supply mask 9D, resets zero, bit 7 unused.
// [RULE_08] Masked supply ignored, its flag stays zero.
// [RULE_09] Input mask 9E, resets zero, bits 7-5 unused.
// [RULE_10] Masked watchdog or logic input changes not logged.
// [RULE_11] Reading input fault latch clears both latches.
// [RULE_12] Summary flag itself can never be masked.
// [RULE_13] Supply change either way sets summary, freezes contents.
// [RULE_14] Event during clearing read wins and stays.
// [RULE_15] Levels sampled each clock, compared with previous.
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SUPPLY_ERROR_MASK_ADDR   8'h9D
`define INPUT_ERROR_MASK_ADDR    8'h9E
`define SUPPLY_FAULT_LATCH_ADDR  8'hDC
`define INPUT_FAULT_LATCH_ADDR   8'hDD

// ----------------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------------
`define FAULT_REG_RESET          8'h00
`define SUMMARY_BIT              7
`define SUPPLY_COUNT             7
`define LOGIC_INPUT_COUNT        4
`define WATCHDOG_BIT             4
`define INPUT_FIELD_WIDTH        5
`define SUPPLY_MASK_USED         8'h7F
`define INPUT_MASK_USED          8'h1F

`endif

// ---- src/fault_pkg.sv ----
/*
 * Types shared by the fault latch and mask block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fault_pkg;

    // ------------------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_s;

    // ------------------------------------------------------------------------
    // Decoded register select
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_NONE         = 3'b000,
        SEL_SUPPLY_MASK  = 3'b001,
        SEL_INPUT_MASK   = 3'b010,
        SEL_SUPPLY_LATCH = 3'b011,
        SEL_INPUT_LATCH  = 3'b100
    } reg_sel_e;

endpackage

// ---- src/level_change_detect.sv ----
/*
 * Synchronises a group of level inputs and flags each change of level.
 * Assumes inputs may come from outside the clock domain; outputs feed same-clock logic.
 */
`timescale 1ns/1ps
module level_change_detect #(
    parameter int WIDTH = 7
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] change_o
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("level_change_detect needs at least one input");
        end
    endgenerate

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;
    logic [2:0]       primed_q;

    // A level that stands at reset reaches prev_q only on the third edge, so comparing
    // starts then and such a level is never reported as a change.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q   <= '0;
            sync_q   <= '0;
            prev_q   <= '0;
            primed_q <= '0;
        end else begin
            meta_q   <= level_i;
            sync_q   <= meta_q;
            prev_q   <= sync_q;
            primed_q <= {primed_q[1:0], 1'b1};
        end
    end

    assign level_o  = sync_q;
    assign change_o = (sync_q ^ prev_q) & {WIDTH{primed_q[2]}}; // [RULE_15]

endmodule

// ---- src/mask_register.sv ----
/*
 * A read/write mask register whose unused bits are held at zero.
 * Assumes the write strobe is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
module mask_register #(
    parameter int         WIDTH     = 8,
    parameter logic [7:0] USED_BITS = 8'hFF
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             wr_en_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    output logic      [WIDTH-1:0] q_o
);

    generate
        if (WIDTH != 8) begin : g_bad_width
            $error("mask_register serves byte-wide registers only");
        end
    endgenerate

    logic [WIDTH-1:0] mask_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q <= '0;
        end else if (wr_en_i) begin
            mask_q <= wdata_i & USED_BITS;
        end
    end

    assign q_o = mask_q;

endmodule

// ---- src/fault_latch_and_mask.sv ----
/*
 * Fault latch and mask register bank of a supply supervisor.
 * Assumes the serial register interface delivers one-cycle read and write
 * strobes on sys_clk_i, and that detector and logic input levels may be asynchronous.
 */
`timescale 1ns/1ps
`include "fault_defs.svh"
module fault_latch_and_mask (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    input  wire fault_pkg::reg_req_s      reg_req_i,
    input  wire logic [`SUPPLY_COUNT-1:0] supply_fault_detector_i,
    input  wire logic [`LOGIC_INPUT_COUNT-1:0] general_logic_input_i,
    input  wire logic                     watchdog_detector_output_i,
    output logic [7:0]                    reg_rdata_o,
    output logic                          reg_rvalid_o,
    output logic                          summary_change_flag_o
);

    // ------------------------------------------------------------------------
    // Layout checks
    // ------------------------------------------------------------------------
    // Both latch views are built byte-wide, so the field counts must fill them.
    generate
        if ((`SUPPLY_COUNT + 1) != 8) begin : g_bad_supply_count
            $error("supply latch needs seven flags below the summary");
        end
        if ((`INPUT_FIELD_WIDTH + 3) != 8) begin : g_bad_input_field
            $error("input latch needs five flags below three reserved bits");
        end
        if (`WATCHDOG_BIT != `LOGIC_INPUT_COUNT) begin : g_bad_watchdog_bit
            $error("watchdog flag must sit just above the logic input flags");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic fault_pkg::reg_sel_e decode_addr(input logic [7:0] addr);
        case (addr)
            `SUPPLY_ERROR_MASK_ADDR:  decode_addr = fault_pkg::SEL_SUPPLY_MASK;
            `INPUT_ERROR_MASK_ADDR:   decode_addr = fault_pkg::SEL_INPUT_MASK;
            `SUPPLY_FAULT_LATCH_ADDR: decode_addr = fault_pkg::SEL_SUPPLY_LATCH;
            `INPUT_FAULT_LATCH_ADDR:  decode_addr = fault_pkg::SEL_INPUT_LATCH;
            default:                  decode_addr = fault_pkg::SEL_NONE;
        endcase
    endfunction

    fault_pkg::reg_sel_e sel;
    logic                wr_supply_mask;
    logic                wr_input_mask;
    logic                clear_read;

    assign sel            = decode_addr(reg_req_i.addr);
    assign wr_supply_mask = reg_req_i.wr && (sel == fault_pkg::SEL_SUPPLY_MASK);
    assign wr_input_mask  = reg_req_i.wr && (sel == fault_pkg::SEL_INPUT_MASK);
    assign clear_read     = reg_req_i.rd && (sel == fault_pkg::SEL_INPUT_LATCH); // [RULE_11]

    // ------------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------------
    logic [7:0] supply_error_mask;
    logic [7:0] input_error_mask;

    mask_register #(
        .WIDTH     (8),
        .USED_BITS (`SUPPLY_MASK_USED)
    ) u_supply_mask (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_supply_mask), // [RULE_07]
        .wdata_i   (reg_req_i.wdata),
        .q_o       (supply_error_mask)
    );

    mask_register #(
        .WIDTH     (8),
        .USED_BITS (`INPUT_MASK_USED)
    ) u_input_mask (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_input_mask), // [RULE_09]
        .wdata_i   (reg_req_i.wdata),
        .q_o       (input_error_mask)
    );

    // ------------------------------------------------------------------------
    // Sampling and change detection
    // ------------------------------------------------------------------------
    logic [`SUPPLY_COUNT-1:0]      supply_level;
    logic [`SUPPLY_COUNT-1:0]      supply_change;
    logic [`INPUT_FIELD_WIDTH-1:0] input_level;
    logic [`INPUT_FIELD_WIDTH-1:0] input_change;

    level_change_detect #(
        .WIDTH     (`SUPPLY_COUNT)
    ) u_supply_detect (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .level_i   (supply_fault_detector_i),
        .level_o   (supply_level),
        .change_o  (supply_change)
    );

    // Watchdog sits above the four logic inputs, matching the latch layout.
    level_change_detect #(
        .WIDTH     (`INPUT_FIELD_WIDTH)
    ) u_input_detect (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .level_i   ({watchdog_detector_output_i, general_logic_input_i}),
        .level_o   (input_level),
        .change_o  (input_change)
    );

    // ------------------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------------------
    logic [`SUPPLY_COUNT-1:0]      supply_event;
    logic [`SUPPLY_COUNT-1:0]      supply_masked_level;
    logic [`INPUT_FIELD_WIDTH-1:0] input_event;
    logic                          any_event;

    assign supply_event        = supply_change & ~supply_error_mask[`SUPPLY_COUNT-1:0]; // [RULE_13]
    assign supply_masked_level = supply_level & ~supply_error_mask[`SUPPLY_COUNT-1:0]; // [RULE_08]
    assign input_event         = input_change & ~input_error_mask[`INPUT_FIELD_WIDTH-1:0]; // [RULE_10]
    // Mask bit 7 is never consulted, so the summary cannot be masked.
    assign any_event           = (|supply_event) || (|input_event); // [RULE_12]

    // ------------------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------------------
    logic                          summary_q;
    logic                          summary_d;
    logic [`SUPPLY_COUNT-1:0]      supply_snap_q;
    logic [`SUPPLY_COUNT-1:0]      supply_snap_d;
    logic [`INPUT_FIELD_WIDTH-1:0] input_flags_q;
    logic [`INPUT_FIELD_WIDTH-1:0] input_flags_d;
    logic                          capture;

    // Only the first event after a clear takes a snapshot; later ones leave it frozen
    // so that software sees the supply state that caused the report.
    assign capture       = any_event && (!summary_q || clear_read); // [RULE_13]
    assign summary_d     = any_event || (summary_q && !clear_read); // [RULE_02] [RULE_14]
    assign supply_snap_d = capture ? supply_masked_level :
                           (clear_read ? '0 : supply_snap_q); // [RULE_03]
    assign input_flags_d = input_event | (clear_read ? '0 : input_flags_q); // [RULE_05] [RULE_06]

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            summary_q     <= 1'b0;
            supply_snap_q <= '0;
            input_flags_q <= '0;
        end else begin
            summary_q     <= summary_d;
            supply_snap_q <= supply_snap_d;
            input_flags_q <= input_flags_d;
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    logic [7:0] supply_latch_view;
    logic [7:0] input_latch_view;
    logic [7:0] read_mux;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic       summary_out_q;

    assign supply_latch_view = {summary_q, supply_snap_q}; // [RULE_01]
    assign input_latch_view  = {3'h0, input_flags_q}; // [RULE_04]

    always_comb begin
        case (sel)
            fault_pkg::SEL_SUPPLY_MASK:  read_mux = supply_error_mask;
            fault_pkg::SEL_INPUT_MASK:   read_mux = input_error_mask;
            fault_pkg::SEL_SUPPLY_LATCH: read_mux = supply_latch_view;
            fault_pkg::SEL_INPUT_LATCH:  read_mux = input_latch_view;
            default:                     read_mux = `FAULT_REG_RESET;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q       <= `FAULT_REG_RESET;
            rvalid_q      <= 1'b0;
            summary_out_q <= 1'b0;
        end else begin
            rdata_q       <= reg_req_i.rd ? read_mux : rdata_q;
            rvalid_q      <= reg_req_i.rd;
            summary_out_q <= summary_d;
        end
    end

    assign reg_rdata_o           = rdata_q;
    assign reg_rvalid_o          = rvalid_q;
    assign summary_change_flag_o = summary_out_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    AST_SUPPLY_LATCH_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_01]
        reg_req_i.rd && sel == fault_pkg::SEL_SUPPLY_LATCH
        |=> reg_rvalid_o && reg_rdata_o == $past({summary_q, supply_snap_q}))
        else $error("supply fault latch read returned wrong data");

    AST_SUMMARY_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_02]
        any_event |=> summary_q ##1 (summary_q || $past(clear_read)))
        else $error("summary flag missed a logged change");

    AST_SNAPSHOT_TAKEN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_03]
        any_event && !summary_q
        |=> supply_snap_q == $past(supply_level & ~supply_error_mask[6:0]))
        else $error("supply snapshot not taken at first event");

    AST_INPUT_RESERVED: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_04]
        reg_req_i.rd && sel == fault_pkg::SEL_INPUT_LATCH |=> reg_rdata_o[7:5] == 3'h0)
        else $error("reserved input latch bits read nonzero");

    AST_LOGIC_INPUT_LOGGED: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_05]
        |(input_change[3:0] & ~input_error_mask[3:0])
        |=> (input_flags_q[3:0] & $past(input_change[3:0] & ~input_error_mask[3:0]))
            == $past(input_change[3:0] & ~input_error_mask[3:0]))
        else $error("logic input change not logged");

    AST_WATCHDOG_LOGGED: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_06]
        input_change[4] && !input_error_mask[4] |=> input_flags_q[4] && summary_q)
        else $error("watchdog change not logged");

    AST_SUPPLY_MASK_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_07]
        wr_supply_mask |=> supply_error_mask == {1'b0, $past(reg_req_i.wdata[6:0])})
        else $error("supply mask write not stored");

    AST_SUPPLY_MASKED_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_08]
        capture |=> (supply_snap_q & $past(supply_error_mask[6:0])) == 7'h00)
        else $error("masked supply flag latched as set");

    AST_INPUT_MASK_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_09]
        wr_input_mask |=> input_error_mask == {3'h0, $past(reg_req_i.wdata[4:0])})
        else $error("input mask write not stored");

    AST_MASKED_INPUT_IGNORED: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_10]
        (input_flags_q & ~$past(input_flags_q) & $past(input_error_mask[4:0])) == 5'h00)
        else $error("masked input change was logged");

    AST_CLEAR_ON_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_11]
        clear_read && !any_event |=> !summary_q && input_flags_q == 5'h00 && supply_snap_q == 7'h00)
        else $error("reading input fault latch did not clear latches");

    AST_EVENT_BEATS_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_14]
        clear_read && any_event |=> summary_q && summary_change_flag_o)
        else $error("event lost in clearing read cycle");

    // ------------------------------------------------------------------------
    // Register map and hold checks
    // ------------------------------------------------------------------------
    AST_READ_ANSWER: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_01]
        reg_rvalid_o == $past(reg_req_i.rd))
        else $error("read answer not one cycle after strobe");

    AST_INPUT_LATCH_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_05]
        reg_req_i.rd && sel == fault_pkg::SEL_INPUT_LATCH
        |=> reg_rdata_o == $past(input_latch_view))
        else $error("input fault latch read returned wrong data");

    AST_SUPPLY_MASK_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_07]
        reg_req_i.rd && sel == fault_pkg::SEL_SUPPLY_MASK
        |=> reg_rdata_o == $past(supply_error_mask))
        else $error("supply mask read returned wrong data");

    AST_INPUT_MASK_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_09]
        reg_req_i.rd && sel == fault_pkg::SEL_INPUT_MASK
        |=> reg_rdata_o == $past(input_error_mask))
        else $error("input mask read returned wrong data");

    AST_SUPPLY_MASK_TOP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_07]
        supply_error_mask[7] == 1'b0)
        else $error("unused supply mask bit set");

    AST_INPUT_MASK_TOP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_09]
        input_error_mask[7:5] == 3'h0)
        else $error("unused input mask bits set");

    AST_LATCH_HOLDS: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_13]
        !any_event && !clear_read
        |=> $stable(summary_q) && $stable(input_flags_q) && $stable(supply_snap_q))
        else $error("latch changed without event or clear");

    AST_SNAPSHOT_FROZEN: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_13]
        summary_q && !clear_read |=> $stable(supply_snap_q))
        else $error("supply snapshot moved before clearing read");

    AST_MASKED_NO_SUMMARY: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_08]
        !summary_q && ((supply_change & ~supply_error_mask[6:0]) == 7'h00)
        && ((input_change & ~input_error_mask[4:0]) == 5'h00) |=> !summary_q)
        else $error("summary set with only masked changes");

    AST_SUPPLY_READ_KEEPS: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_11]
        reg_req_i.rd && sel == fault_pkg::SEL_SUPPLY_LATCH && summary_q |=> summary_q)
        else $error("supply fault latch read cleared the summary");

    AST_EVENT_SNAPSHOT: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE_14]
        clear_read && any_event |=> supply_snap_q == $past(supply_masked_level)
        && input_flags_q == $past(input_event))
        else $error("event in clearing read cycle not captured alone");

endmodule

// ---- verification/reg_host_model.sv ----
/*
 * Host-side model of the register port: issues one-cycle read and write strobes.
 * Assumes the block answers a read with a one-cycle valid pulse on the same clock.
 */
`timescale 1ns/1ps
module reg_host_model (
    input  wire logic           sys_clk_i,
    output fault_pkg::reg_req_s reg_req_o,
    input  wire logic [7:0]     reg_rdata_i,
    input  wire logic           reg_rvalid_i
);
    initial begin
        reg_req_o = '0;
    end

    // ------------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------------
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk_i);
        reg_req_o <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge sys_clk_i);
        reg_req_o <= '0;
    endtask

    // A missing answer leaves the data unknown, so the caller's compare fails.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        int n;
        data = 'x;
        @(posedge sys_clk_i);
        reg_req_o <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge sys_clk_i);
        reg_req_o <= '0;
        for (n = 0; n < 4; n++) begin
            #1;
            if (reg_rvalid_i === 1'b1) begin
                data = reg_rdata_i;
                break;
            end
            @(posedge sys_clk_i);
        end
    endtask
endmodule

// ---- verification/fault_latch_and_mask_tb_top.sv ----
/*
 * Self-checking testbench of the fault latch and mask bank.
 * Assumes the host model drives the register port and the bench drives all levels.
 */
`timescale 1ns/1ps
module fault_latch_and_mask_tb_top;
    logic                sys_clk;
    logic                rst;
    fault_pkg::reg_req_s req;
    logic [6:0]          supply;
    logic [3:0]          general_logic_input;
    logic                wdo;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                summary;
    int                  errors;
    int                  n_tests;

    fault_latch_and_mask uut (
        .sys_clk_i                  (sys_clk),
        .rst_i                      (rst),
        .reg_req_i                  (req),
        .supply_fault_detector_i    (supply),
        .general_logic_input_i      (general_logic_input),
        .watchdog_detector_output_i (wdo),
        .reg_rdata_o                (rdata),
        .reg_rvalid_o               (rvalid),
        .summary_change_flag_o      (summary)
    );

    reg_host_model host (
        .sys_clk_i    (sys_clk),
        .reg_req_o    (req),
        .reg_rdata_i  (rdata),
        .reg_rvalid_i (rvalid)
    );

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(addr, d);
        check(d, exp);
    endtask

    // Sync and compare take up to three cycles, so eight is ample margin.
    task automatic settle();
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic print_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset_values();
        rd_check(8'h9D, 8'h00);
        rd_check(8'h9E, 8'h00);
        rd_check(8'hDC, 8'h00);
        rd_check(8'hDD, 8'h00);
        rd_check(8'h55, 8'h00);
    endtask

    task automatic t_mask_rw();
        host.write_reg(8'h9D, 8'hFF);
        host.write_reg(8'h9E, 8'hFF);
        host.write_reg(8'hDC, 8'h5A);
        host.write_reg(8'hDD, 8'h5A);
        rd_check(8'h9D, 8'h7F);
        rd_check(8'h9E, 8'h1F);
        rd_check(8'hDC, 8'h00);
        rd_check(8'hDD, 8'h00);
        host.write_reg(8'h9D, 8'h00);
        host.write_reg(8'h9E, 8'h00);
        rd_check(8'h9D, 8'h00);
    endtask

    task automatic t_supply_walk();
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            supply <= 7'h01 << i;
            settle();
            check({7'h00, summary}, 8'h01);
            rd_check(8'hDC, 8'h80 | (8'h01 << i));
            rd_check(8'hDD, 8'h00);
            rd_check(8'hDC, 8'h00);
            check({7'h00, summary}, 8'h00);
            @(posedge sys_clk);
            supply <= 7'h00;
            settle();
            rd_check(8'hDC, 8'h80);
            rd_check(8'hDD, 8'h00);
        end
    endtask

    // A second change before the clearing read must not move the snapshot.
    task automatic t_freeze();
        @(posedge sys_clk);
        supply <= 7'h08;
        settle();
        supply <= 7'h00;
        settle();
        rd_check(8'hDC, 8'h88);
        rd_check(8'hDD, 8'h00);
        rd_check(8'hDC, 8'h00);
    endtask

    task automatic t_inputs();
        for (int j = 0; j < 5; j++) begin
            @(posedge sys_clk);
            if (j < 4) begin
                general_logic_input <= general_logic_input ^ (4'h1 << j);
            end else begin
                wdo <= ~wdo;
            end
            settle();
            rd_check(8'hDC, 8'h80);
            rd_check(8'hDD, 8'h01 << j);
        end
        @(posedge sys_clk);
        general_logic_input <= general_logic_input ^ 4'h1;
        settle();
        general_logic_input <= general_logic_input ^ 4'h4;
        settle();
        rd_check(8'hDD, 8'h05);
        rd_check(8'hDD, 8'h00);
    endtask

    task automatic t_masks();
        host.write_reg(8'h9D, 8'h7F);
        host.write_reg(8'h9E, 8'h1F);
        @(posedge sys_clk);
        supply <= 7'h7F;
        general_logic_input <= general_logic_input ^ 4'hF;
        wdo <= ~wdo;
        settle();
        check({7'h00, summary}, 8'h00);
        rd_check(8'hDC, 8'h00);
        rd_check(8'hDD, 8'h00);
        @(posedge sys_clk);
        supply <= 7'h00;
        settle();
        host.write_reg(8'h9D, 8'h08);
        host.write_reg(8'h9E, 8'h1E);
        @(posedge sys_clk);
        supply <= 7'h09;
        general_logic_input <= general_logic_input ^ 4'h3;
        wdo <= ~wdo;
        settle();
        rd_check(8'hDC, 8'h81);
        rd_check(8'hDD, 8'h01);
    endtask

    // The change reaches the latch on the very edge that samples the clearing read.
    task automatic t_event_on_clear();
        logic [7:0] d;
        @(posedge sys_clk);
        supply <= 7'h02;
        @(posedge sys_clk);
        host.read_reg(8'hDD, d);
        check(d, 8'h00);
        check({7'h00, summary}, 8'h01);
        rd_check(8'hDC, 8'h82);
        rd_check(8'hDD, 8'h00);
    endtask

    // A level that already stands when reset ends is not a change.
    task automatic t_mid_reset();
        @(posedge sys_clk);
        supply <= 7'h10;
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        check({7'h00, summary}, 8'h00);
        rd_check(8'h9D, 8'h00);
        rd_check(8'hDC, 8'h00);
        rd_check(8'hDD, 8'h00);
    endtask

    // ------------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        errors = 0;
        n_tests = 0;
        rst = 1'b1;
        supply = 7'h00;
        general_logic_input = 4'h0;
        wdo = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        settle();
        t_reset_values();
        t_mask_rw();
        t_supply_walk();
        t_freeze();
        t_inputs();
        t_event_on_clear();
        t_masks();
        t_mid_reset();
        print_verdict();
    end

    // The sequence needs well under 2000 cycles; this limit only cuts a hang.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        print_verdict();
    end
endmodule
